// File: verilog/pmt_map.vh
// register map, field positions and reset values of the period match timer
`ifndef PMT_MAP_VH
`define PMT_MAP_VH

// printed offsets are not all multiples of four: they are indices, byte address = 4 * index
`define PMT_IDX_FLAGS      8'h0c
`define PMT_IDX_COUNT      8'h11
`define PMT_IDX_CONTROL    8'h12
`define PMT_IDX_ENABLES    8'h8c
`define PMT_IDX_PERIOD     8'h92

`define PMT_RST_FLAGS      8'h00
`define PMT_RST_COUNT      8'h00
`define PMT_RST_CONTROL    7'h00
`define PMT_RST_ENABLES    8'h00
`define PMT_RST_PERIOD     8'hff

`define PMT_BIT_MATCH_FLAG 1
`define PMT_BIT_RUN        2
`define PMT_POST_MSB       6
`define PMT_POST_LSB       3
`define PMT_PRE_MSB        1
`define PMT_PRE_LSB        0

`define PMT_PRE_DIV1       2'b00
`define PMT_PRE_DIV4       2'b01
`define PMT_PRE_LAST4      4'h3
`define PMT_PRE_LAST16     4'hf

`endif

// File: verilog/pmt_prescaler.v
// clock prescaler producing one increment tick per 1, 4 or 16 input ticks
`timescale 1ns/1ns
`include "pmt_map.vh"

module pmt_prescaler (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       clear_i,
  input  wire       tick_i,
  input  wire [1:0] select_i,
  output reg        tick_o
);

  reg  [3:0] count_q;
  reg  [3:0] last;

  always @* begin
    if (select_i == `PMT_PRE_DIV1) begin
      last = 4'h0;
    end else if (select_i == `PMT_PRE_DIV4) begin
      last = `PMT_PRE_LAST4;
    end else begin
      last = `PMT_PRE_LAST16;
    end
  end

  always @* begin
    tick_o = tick_i && (count_q == last);
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_q <= 4'h0;
    end else if (clear_i) begin
      count_q <= 4'h0;
    end else if (tick_i) begin
      if (count_q >= last) begin
        count_q <= 4'h0;
      end else begin
        count_q <= count_q + 4'h1;
      end
    end
  end

endmodule // pmt_prescaler

// File: verilog/pmt_timer.v
// period match timer with prescaler, postscaler, interrupt and APB register slave
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
`include "pmt_map.vh"

module pmt_timer #(
  parameter CLK_DIV = 4
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [3:0]  pstrb_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  output reg         irq_o,
  output reg         sync_serial_clk_o,
  output reg         pwm_period_o,
  output reg  [7:0]  pwm_count_o
);

  localparam [7:0] LAST_DIV = CLK_DIV - 1;

  reg  [7:0] timer_count_q;
  reg  [6:0] timer_control_q;
  reg  [7:0] period_value_q;
  reg  [7:0] flags_q;
  reg  [7:0] enables_q;
  reg  [7:0] osc_div_q;
  reg  [3:0] post_q;
  reg        setup_q;

  wire       acc_req;
  wire       wr_acc;
  wire       rd_acc;
  wire [9:0] word_idx;
  wire       sel_flags;
  wire       sel_count;
  wire       sel_control;
  wire       sel_enables;
  wire       sel_period;
  wire       mapped;
  wire       wr_lane0;
  wire       wr_count;
  wire       wr_control;
  wire       run;
  wire       cyc_tick;
  wire       inc_tick;
  wire       match_now;
  wire       post_done;
  wire [3:0] post_last;

  function idx_hit;
    input [9:0] idx;
    input [7:0] reg_idx;
    begin
      idx_hit = (idx == {2'b00, reg_idx});
    end
  endfunction

  // apb: one wait state; a write lands at the edge where the master samples pready high
  assign acc_req     = psel_i && penable_i && !pready_o;
  assign word_idx    = paddr_i[11:2];
  assign sel_flags   = idx_hit(word_idx, `PMT_IDX_FLAGS);
  assign sel_count   = idx_hit(word_idx, `PMT_IDX_COUNT);
  assign sel_control = idx_hit(word_idx, `PMT_IDX_CONTROL);
  assign sel_enables = idx_hit(word_idx, `PMT_IDX_ENABLES);
  assign sel_period  = idx_hit(word_idx, `PMT_IDX_PERIOD);
  assign mapped      = sel_flags | sel_count | sel_control | sel_enables | sel_period;
  assign wr_acc      = psel_i && penable_i && pready_o && pwrite_i && mapped;
  assign rd_acc      = acc_req && !pwrite_i;
  assign wr_lane0    = wr_acc && pstrb_i[0];
  assign wr_count    = wr_lane0 && sel_count;
  assign wr_control  = wr_lane0 && sel_control;

  assign run       = timer_control_q[`PMT_BIT_RUN];
  assign cyc_tick  = run && (osc_div_q == LAST_DIV);
  assign match_now = inc_tick && (timer_count_q == period_value_q);
  assign post_last = timer_control_q[`PMT_POST_MSB:`PMT_POST_LSB];
  assign post_done = match_now && (post_q == post_last);

  pmt_prescaler u_pre (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .clear_i  (wr_count || wr_control),
    .tick_i   (cyc_tick),
    .select_i (timer_control_q[`PMT_PRE_MSB:`PMT_PRE_LSB]),
    .tick_o   (inc_tick)
  );

  // instruction-cycle divider: the oscillator divided by CLK_DIV (four by default), frozen while stopped
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_div_q <= 8'h00;
    end else if (!run) begin
      osc_div_q <= osc_div_q;
    end else if (osc_div_q == LAST_DIV) begin
      osc_div_q <= 8'h00;
    end else begin
      osc_div_q <= osc_div_q + 8'h01;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_count_q <= `PMT_RST_COUNT;
    end else if (wr_count) begin
      timer_count_q <= pwdata_i[7:0];
    end else if (match_now) begin
      timer_count_q <= 8'h00;
    end else if (inc_tick) begin
      timer_count_q <= timer_count_q + 8'h01;
    end
  end // control writes never touch the count

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      post_q <= 4'h0;
    end else if (wr_count || wr_control) begin
      post_q <= 4'h0;
    end else if (post_done) begin
      post_q <= 4'h0;
    end else if (match_now) begin
      post_q <= post_q + 4'h1;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_control_q <= `PMT_RST_CONTROL;
      period_value_q  <= `PMT_RST_PERIOD;
      enables_q       <= `PMT_RST_ENABLES;
    end else begin
      if (wr_control) begin
        timer_control_q <= pwdata_i[6:0];
      end
      if (wr_lane0 && sel_period) begin
        period_value_q <= pwdata_i[7:0];
      end
      if (wr_lane0 && sel_enables) begin
        enables_q <= pwdata_i[7:0];
      end
    end
  end

  // sticky flags: write one to clear, a same-cycle set wins over the clear
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_q <= `PMT_RST_FLAGS;
    end else begin
      if (wr_lane0 && sel_flags) begin
        flags_q <= flags_q & ~pwdata_i[7:0];
      end
      if (post_done) begin
        flags_q[`PMT_BIT_MATCH_FLAG] <= 1'b1;
      end
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      setup_q   <= 1'b0;
    end else begin
      setup_q   <= psel_i && !penable_i;
      pready_o  <= acc_req;
      pslverr_o <= acc_req && !mapped;
      if (rd_acc) begin
        if (sel_flags) begin
          prdata_o <= {24'h000000, flags_q};
        end else if (sel_count) begin
          prdata_o <= {24'h000000, timer_count_q};
        end else if (sel_control) begin
          prdata_o <= {25'h0000000, timer_control_q};
        end else if (sel_enables) begin
          prdata_o <= {24'h000000, enables_q};
        end else if (sel_period) begin
          prdata_o <= {24'h000000, period_value_q};
        end else begin
          prdata_o <= 32'h0000_0000;
        end
      end else begin
        prdata_o <= 32'h0000_0000;
      end
    end
  end

  // outputs registered, so side units see the match one cycle after it occurs
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o             <= 1'b0;
      sync_serial_clk_o <= 1'b0;
      pwm_period_o      <= 1'b0;
      pwm_count_o       <= 8'h00;
    end else begin
      irq_o             <= |(flags_q & enables_q);
      sync_serial_clk_o <= match_now;
      pwm_period_o      <= match_now;
      pwm_count_o       <= timer_count_q;
    end
  end

endmodule // pmt_timer

// File: testbench/pmt_timer_checker.sv
// port assertions for the period match timer
`timescale 1ns/1ns
module pmt_timer_checker (
  input wire        clk_i,
  input wire        rst_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire        irq_o,
  input wire        sync_serial_clk_o,
  input wire        pwm_period_o,
  input wire [7:0]  pwm_count_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_taken;
    psel_i && penable_i && !pready_o;
  endsequence
  chk_ready_next: assert property (s_taken |=> pready_o)
    else $error("no ready after access");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  chk_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("ready without access");
  chk_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside answer");
  chk_match_same: assert property (sync_serial_clk_o == pwm_period_o)
    else $error("match outputs differ");
  // the count moves by one or wraps, except just after a register access
  chk_count_step: assert property ($changed(pwm_count_o) |-> pwm_count_o == 8'h00 ||
    pwm_count_o == $past(pwm_count_o) + 8'h01 || $past(pready_o) || $past(pready_o, 2))
    else $error("count jumped");
  chk_irq_fall: assert property ($fell(irq_o) |-> $past(pready_o) || $past(pready_o, 2))
    else $error("interrupt dropped without write");
endmodule // pmt_timer_checker

bind pmt_timer pmt_timer_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .irq_o(irq_o), .sync_serial_clk_o(sync_serial_clk_o), .pwm_period_o(pwm_period_o),
  .pwm_count_o(pwm_count_o));

// File: testbench/test_period_match_timer_8bit.sv
// self-checking bench for the period match timer
`timescale 1ns/1ns
`include "pmt_map.vh"
module test_period_match_timer_8bit;
  reg         clk_i;
  reg         rst_i;
  reg         psel_i;
  reg         penable_i;
  reg         pwrite_i;
  reg  [11:0] paddr_i;
  reg  [31:0] pwdata_i;
  reg  [3:0]  pstrb_i;
  wire [31:0] prdata_o;
  wire        pready_o;
  wire        pslverr_o;
  wire        irq_o;
  wire        ser_w;
  wire [7:0]  cnt_w;
  integer     err_total, cmp_count, cyc, last, gap, npulse, i, p, c, q;
  reg  [31:0] rs;
  reg  [31:0] rd;
  reg         er;
  // divider of 1 keeps the runs short
  pmt_timer #(.CLK_DIV(1)) DUT (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .irq_o(irq_o), .sync_serial_clk_o(ser_w), .pwm_period_o(), .pwm_count_o(cnt_w));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (ser_w === 1'b1) begin
      npulse <= npulse + 1;
      gap <= cyc - last;
      last <= cyc;
    end
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task conclude;
    begin
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e, input [63:0] nm);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("MISMATCH %0s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task apb(input [7:0] x, input w, input [7:0] d);
    integer n;
    begin
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= {2'b00, x, 2'b00};
      pwdata_i <= {24'h0, d};
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      @(negedge clk_i);
      while (pready_o !== 1'b1 && n < 50) begin
        @(negedge clk_i);
        n = n + 1;
      end
      rd = prdata_o;
      er = pslverr_o;
      @(posedge clk_i);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (n >= 50) begin
        err_total = err_total + 1;
        conclude;
      end
    end
  endtask
  task rdc(input [7:0] x, input [31:0] e, input [63:0] nm);
    begin
      apb(x, 1'b0, 8'h00);
      chk(rd, e, nm);
    end
  endtask
  initial begin
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    pstrb_i = 4'h1;
    err_total = 0;
    cmp_count = 0;
    cyc = 0;
    last = 0;
    gap = 0;
    npulse = 0;
    rs = 32'h31d8;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(`PMT_IDX_PERIOD, 32'hff, "period");
    rdc(`PMT_IDX_COUNT, 32'h0, "count");
    rdc(`PMT_IDX_CONTROL, 32'h0, "control");
    rdc(`PMT_IDX_FLAGS, 32'h0, "flags");
    rdc(8'h3f, 32'h0, "unmapped");
    chk(er, 32'h1, "slverr");
    pstrb_i <= 4'h0;
    apb(`PMT_IDX_PERIOD, 1'b1, 8'h11);
    pstrb_i <= 4'h1;
    rdc(`PMT_IDX_PERIOD, 32'hff, "strobe");
    apb(`PMT_IDX_CONTROL, 1'b1, 8'h80);
    rdc(`PMT_IDX_CONTROL, 32'h0, "bit7");
    apb(`PMT_IDX_ENABLES, 1'b1, 8'h02);
    rdc(`PMT_IDX_ENABLES, 32'h2, "enables");
    $display("test registers done");
    for (i = 0; i < 4; i = i + 1) begin
      rs = lfsr(rs);
      p = 2 + rs[1:0];
      q = i * 5;
      c = (i == 0) ? 1 : (i == 1) ? 4 : 16;
      apb(`PMT_IDX_PERIOD, 1'b1, p[7:0]);
      apb(`PMT_IDX_COUNT, 1'b1, 8'h00);
      apb(`PMT_IDX_CONTROL, 1'b1, {1'b0, q[3:0], 1'b1, i[1:0]});
      npulse = 0;
      q = q + 1;
      while (irq_o !== 1'b1 && cyc < 90000) @(posedge clk_i);
      if (irq_o !== 1'b1) begin
        err_total = err_total + 1;
        conclude;
      end
      chk(npulse, q, "posts");
      if (q > 1) chk(gap, c * (p + 1), "gap");
      apb(`PMT_IDX_CONTROL, 1'b0, 8'h00);
      apb(`PMT_IDX_CONTROL, 1'b1, {1'b0, i[1:0]});
      apb(`PMT_IDX_COUNT, 1'b0, 8'h00);
      p = rd;
      c = npulse;
      repeat (40) @(posedge clk_i);
      rdc(`PMT_IDX_COUNT, p, "hold");
      chk(npulse, c, "stopped");
      chk(cnt_w, p, "pwmcount");
      rdc(`PMT_IDX_FLAGS, 32'h2, "sticky");
      apb(`PMT_IDX_FLAGS, 1'b1, 8'h02);
      rdc(`PMT_IDX_FLAGS, 32'h0, "clear");
      chk(irq_o, 32'h0, "irq");
      $display("test scaler %0d done", i);
    end
    rs = lfsr(rs);
    apb(`PMT_IDX_COUNT, 1'b1, rs[7:0]);
    apb(`PMT_IDX_CONTROL, 1'b1, 8'h78);
    rdc(`PMT_IDX_COUNT, {24'h0, rs[7:0]}, "keep");
    apb(`PMT_IDX_ENABLES, 1'b1, 8'h00);
    apb(`PMT_IDX_COUNT, 1'b1, 8'h00);
    apb(`PMT_IDX_CONTROL, 1'b1, 8'h04);
    repeat (100) @(posedge clk_i);
    chk(irq_o, 32'h0, "mask");
    rdc(`PMT_IDX_FLAGS, 32'h2, "flag");
    conclude;
  end
endmodule // test_period_match_timer_8bit
